/* File: hdl/serdes_ctrl_pkg.sv */
// Constants and types shared by the transceiver control logic.
// Assumes one 100 MHz reference clock drives every register.
package serdes_ctrl_pkg;

    // ==========================================
    // Ternary configuration pins
    // ==========================================
    // Two-bit code per three-level pin; 2'h3 is an open pin
    localparam logic [1:0] TERN_LOW_CODE = 2'h0;
    localparam logic [1:0] TERN_MID_CODE = 2'h1;
    localparam logic [1:0] TERN_HIGH_CODE = 2'h2;

    typedef enum logic [1:0] {TERN_LOW, TERN_MID, TERN_HIGH} tern_t;

    // Bit-rate ranges: 195-400, 400-800 and 800-1500 MBaud
    typedef enum logic [1:0] {RANGE_LOW, RANGE_MID, RANGE_HIGH} rate_range_t;

    // Open or floating pin reads as the middle level
    function automatic tern_t tern_decode(input logic [1:0] code);
        tern_t t;
        unique case (code)
            TERN_LOW_CODE: t = TERN_LOW;
            TERN_HIGH_CODE: t = TERN_HIGH;
            default: t = TERN_MID;
        endcase
        return t;
    endfunction : tern_decode

    // ==========================================
    // Character stream
    // ==========================================
    localparam int CHAR_W = 9; // Control flag above one byte
    localparam logic [8:0] K28_5_CHAR = 9'h1bc;

    // ==========================================
    // Elasticity buffer
    // ==========================================
    localparam int EB_DEPTH = 8;
    localparam int EB_NOMINAL = 4;
    localparam int EB_LOW_MARK = 2;
    localparam int EB_HIGH_MARK = 6;

    // ==========================================
    // Reset behaviour
    // ==========================================
    localparam int SETTLE_CYCLES = 8;
    localparam int SETTLE_W = 4;
    localparam logic [1:0] OE_LATCH_RST = 2'h0;
    localparam logic [1:0] BIST_LATCH_RST = 2'h3;
    localparam logic RXPWR_LATCH_RST = 1'b0;

endpackage : serdes_ctrl_pkg

/* File: hdl/pair_buffer.sv */
// Two-entry valid/ready buffer for the received character path.
// Assumes a single clock; flush empties it in one cycle.
`timescale 1ns/1ps
module pair_buffer #(
    parameter int WIDTH = 9
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    typedef struct packed {
        logic out_v;
        logic [WIDTH-1:0] out_d;
        logic skid_v;
        logic [WIDTH-1:0] skid_d;
    } buf_t;

    buf_t st_r;
    buf_t st_nxt;

    // Second entry catches the word accepted during a stall
    always_comb begin
        st_nxt = st_r;
        if (st_r.out_v && !out_ready) begin
            if (in_valid && !st_r.skid_v) begin
                st_nxt.skid_v = 1'b1;
                st_nxt.skid_d = in_data;
            end
        end else if (st_r.skid_v) begin
            st_nxt.out_v = 1'b1;
            st_nxt.out_d = st_r.skid_d;
            st_nxt.skid_v = 1'b0;
        end else begin
            st_nxt.out_v = in_valid;
            if (in_valid) begin
                st_nxt.out_d = in_data;
            end
        end
        if (flush) begin
            st_nxt.out_v = 1'b0;
            st_nxt.skid_v = 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_ready = !st_r.skid_v;
    assign out_valid = st_r.out_v;
    assign out_data = st_r.out_d;

    a_hold_stall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        out_valid && !out_ready && !flush |=> out_valid && $stable(out_data))
        else $error("buffered word changed during stall");

endmodule : pair_buffer

/* File: hdl/serdes_ctrl.sv */
// Control logic of a single-channel serial transceiver: rate range,
// parallel clock choice, receive elasticity buffer, reset, enable
// latches, serial input selection and loopback.
// Assumes every input is synchronous to sys_clk, the reference clock.
`timescale 1ns/1ps
module serdes_ctrl
    import serdes_ctrl_pkg::*;
#(
    parameter int DEPTH = serdes_ctrl_pkg::EB_DEPTH,
    parameter int NOMINAL = serdes_ctrl_pkg::EB_NOMINAL,
    parameter int LOW_MARK = serdes_ctrl_pkg::EB_LOW_MARK,
    parameter int HIGH_MARK = serdes_ctrl_pkg::EB_HIGH_MARK
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic device_reset_n,
    input wire logic [1:0] serial_rate_range_select,
    input wire logic [1:0] tx_reference_rate_select,
    input wire logic [1:0] tx_clock_source_select,
    input wire logic [1:0] rx_clock_source_select,
    input wire logic decoder_enable,
    input wire logic [1:0] boe,
    input wire logic output_enable_latch_enable,
    input wire logic selftest_latch_enable,
    input wire logic rx_power_latch_enable,
    input wire logic serial_input_select,
    input wire logic primary_serial_input,
    input wire logic secondary_serial_input,
    input wire logic loopback_enable,
    input wire logic tx_serial_stream,
    input wire logic rx_char_valid,
    output logic rx_char_ready,
    input wire logic [serdes_ctrl_pkg::CHAR_W-1:0] rx_char,
    output logic rx_out_valid,
    input wire logic rx_out_ready,
    output logic [serdes_ctrl_pkg::CHAR_W-1:0] rx_out_char,
    output serdes_ctrl_pkg::rate_range_t pll_range,
    output logic tx_capture_on_ref,
    output logic rx_out_on_ref,
    output logic rx_out_on_recovered,
    output logic config_error,
    output logic cdr_serial_in,
    output logic serial_out_primary,
    output logic serial_out_secondary,
    output logic [1:0] serial_out_en,
    output logic [1:0] selftest_en,
    output logic rx_power_en,
    output logic char_inserted,
    output logic char_dropped,
    output logic eb_overflow,
    output logic device_ready
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FILL_NOM = (AW+1)'(NOMINAL);
    localparam logic [AW:0] FILL_LOW = (AW+1)'(LOW_MARK);
    localparam logic [AW:0] FILL_HIGH = (AW+1)'(HIGH_MARK);
    localparam logic [AW:0] FILL_FULL = (AW+1)'(DEPTH);
    localparam logic [SETTLE_W-1:0] SETTLE_END = SETTLE_W'(SETTLE_CYCLES);

    typedef struct packed {
        logic [DEPTH-1:0][CHAR_W-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] fill;
        logic last_framing;
        logic [SETTLE_W-1:0] settle;
        logic ready;
        logic in_reset;
        logic [1:0] oe_latch;
        logic [1:0] bist_latch;
        logic rxpwr_latch;
        logic cdr;
        logic out1;
        logic out2;
        logic ins;
        logic drop;
        logic ovf;
    } state_t;

    // Buffer primed with framing characters at its nominal offset
    localparam state_t RST_ST = '{
        mem: {DEPTH{K28_5_CHAR}},
        wptr: AW'(NOMINAL),
        rptr: '0,
        fill: FILL_NOM,
        last_framing: 1'b0,
        settle: '0,
        ready: 1'b0,
        in_reset: 1'b1,
        oe_latch: OE_LATCH_RST,
        bist_latch: BIST_LATCH_RST,
        rxpwr_latch: RXPWR_LATCH_RST,
        cdr: 1'b0,
        out1: 1'b0,
        out2: 1'b0,
        ins: 1'b0,
        drop: 1'b0,
        ovf: 1'b0
    };

    state_t st_r;
    state_t st_nxt;
    tern_t rate_t;
    tern_t tx_reference_rate_select_t;
    tern_t txsel_t;
    tern_t rxsel_t;
    logic eb_active;
    logic [1:0] oe_now;
    logic [1:0] bist_now;
    logic rxpwr_now;
    logic sk_in_valid;
    logic sk_in_ready;
    logic [CHAR_W-1:0] sk_in_data;
    logic pop;
    logic wr;
    logic drop_now;
    logic ins_now;

    // ==========================================
    // Configuration decode
    // ==========================================
    // Open pins decode as middle level
    assign rate_t = tern_decode(serial_rate_range_select);
    assign tx_reference_rate_select_t = tern_decode(tx_reference_rate_select);
    assign txsel_t = tern_decode(tx_clock_source_select);
    assign rxsel_t = tern_decode(rx_clock_source_select);

    // PLL range follows the rate pin
    always_comb begin
        unique case (rate_t)
            TERN_LOW: pll_range = RANGE_LOW;
            TERN_MID: pll_range = RANGE_MID;
            TERN_HIGH: pll_range = RANGE_HIGH;
        endcase
    end

    // Parallel interface clock choice
    assign tx_capture_on_ref = (txsel_t == TERN_LOW);
    assign eb_active = (rxsel_t == TERN_LOW) && decoder_enable;
    assign rx_out_on_ref = eb_active;
    assign rx_out_on_recovered = !eb_active;

    // Flags combinations the host is not allowed to set
    assign config_error = ((rate_t == TERN_LOW) && (tx_reference_rate_select_t == TERN_HIGH))
        || (rxsel_t == TERN_HIGH)
        || (!decoder_enable && (rxsel_t != TERN_MID));

    // ==========================================
    // Enable latches
    // ==========================================
    // Open latch passes the pins through; reset forces all off
    assign oe_now = output_enable_latch_enable ? boe : st_r.oe_latch;
    assign bist_now = selftest_latch_enable ? boe : st_r.bist_latch;
    assign rxpwr_now = rx_power_latch_enable ? boe[0] : st_r.rxpwr_latch;
    assign serial_out_en = st_r.in_reset ? 2'h0 : oe_now;
    assign selftest_en = st_r.in_reset ? 2'h0 : ~bist_now;
    assign rx_power_en = st_r.in_reset ? 1'b0 : rxpwr_now;

    // ==========================================
    // Next-state logic
    // ==========================================
    // Elasticity buffer, serial routing, latches and reset settling
    always_comb begin
        st_nxt = st_r;
        pop = 1'b0;
        wr = 1'b0;
        drop_now = 1'b0;
        ins_now = 1'b0;
        sk_in_valid = 1'b0;
        sk_in_data = rx_char;
        st_nxt.in_reset = 1'b0;
        // Receive side: buffered or passed straight on
        if (eb_active) begin
            if (sk_in_ready) begin
                if (st_r.fill <= FILL_LOW && st_r.last_framing) begin
                    ins_now = 1'b1;
                    sk_in_valid = 1'b1;
                    sk_in_data = K28_5_CHAR;
                    st_nxt.last_framing = 1'b0;
                end else if (st_r.fill != '0) begin
                    pop = 1'b1;
                    sk_in_valid = 1'b1;
                    sk_in_data = st_r.mem[st_r.rptr];
                    st_nxt.last_framing = (st_r.mem[st_r.rptr] == K28_5_CHAR);
                    st_nxt.rptr = st_r.rptr + 1'b1;
                end
            end
            drop_now = rx_char_valid && (rx_char == K28_5_CHAR)
                && (st_r.fill >= FILL_HIGH);
            wr = rx_char_valid && !drop_now && (st_r.fill != FILL_FULL);
            if (wr) begin
                st_nxt.mem[st_r.wptr] = rx_char;
                st_nxt.wptr = st_r.wptr + 1'b1;
            end
            st_nxt.fill = st_r.fill + (AW+1)'(wr) - (AW+1)'(pop);
        end else begin
            sk_in_valid = rx_char_valid;
        end
        st_nxt.ins = ins_now;
        st_nxt.drop = drop_now;
        st_nxt.ovf = eb_active && rx_char_valid && !drop_now && !wr;
        // Serial routing and loopback
        if (loopback_enable) begin
            st_nxt.cdr = tx_serial_stream;
        end else begin
            st_nxt.cdr = serial_input_select ? primary_serial_input
                : secondary_serial_input;
        end
        st_nxt.out1 = oe_now[0] && (loopback_enable || tx_serial_stream);
        st_nxt.out2 = oe_now[1] && (loopback_enable || tx_serial_stream);
        // Latches follow the pins while open
        if (output_enable_latch_enable) begin
            st_nxt.oe_latch = boe;
        end
        if (selftest_latch_enable) begin
            st_nxt.bist_latch = boe;
        end
        if (rx_power_latch_enable) begin
            st_nxt.rxpwr_latch = boe[0];
        end
        // Settling count after reset release
        if (st_r.settle != SETTLE_END) begin
            st_nxt.settle = st_r.settle + 1'b1;
        end else begin
            st_nxt.ready = 1'b1;
        end
        // Synchronous device reset overrides everything
        if (!device_reset_n) begin
            st_nxt = RST_ST;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= RST_ST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // Output buffer
    // ==========================================
    // Two-entry buffer; bypass mode relies on it for receiver stalls
    pair_buffer #(
        .WIDTH(CHAR_W)
    ) u_out_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .flush(!device_reset_n),
        .in_valid(sk_in_valid),
        .in_ready(sk_in_ready),
        .in_data(sk_in_data),
        .out_valid(rx_out_valid),
        .out_ready(rx_out_ready),
        .out_data(rx_out_char)
    );

    assign rx_char_ready = eb_active ? 1'b1 : sk_in_ready;
    assign cdr_serial_in = st_r.cdr;
    assign serial_out_primary = st_r.out1;
    assign serial_out_secondary = st_r.out2;
    assign char_inserted = st_r.ins;
    assign char_dropped = st_r.drop;
    assign eb_overflow = st_r.ovf;
    assign device_ready = st_r.ready;

    // ==========================================
    // Assertions
    // ==========================================
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_range_float: assert property (
        serial_rate_range_select == 2'h3 |-> pll_range == RANGE_MID)
        else $error("floating rate pin not read as middle");

    a_rx_ref_mode: assert property (
        rx_clock_source_select == TERN_LOW_CODE && decoder_enable
        |-> rx_out_on_ref && rx_char_ready && !rx_out_on_recovered)
        else $error("reference-timed receive mode not taken");

    a_input_route: assert property (
        device_reset_n && !loopback_enable
        |=> cdr_serial_in == $past(serial_input_select ? primary_serial_input
            : secondary_serial_input))
        else $error("wrong serial input routed");

    a_loop_drivers: assert property (
        device_reset_n && loopback_enable && oe_now == 2'h3
        |=> serial_out_primary && serial_out_secondary
            && cdr_serial_in == $past(tx_serial_stream))
        else $error("loopback not applied");

    a_reset_latches: assert property (
        !device_reset_n ##1 !output_enable_latch_enable && !selftest_latch_enable
            && !rx_power_latch_enable
        |-> serial_out_en == 2'h0 && selftest_en == 2'h0 && !rx_power_en)
        else $error("enable latches not cleared by reset");

    a_reset_ptrs: assert property (
        !device_reset_n |=> st_r.fill == FILL_NOM && st_r.rptr == '0
            && !rx_out_valid && !device_ready)
        else $error("buffer not at nominal offset after reset");

    a_settle_time: assert property (
        !device_reset_n ##1 device_reset_n |-> ##[0:15] (device_ready || !device_reset_n))
        else $error("not ready 16 cycles after reset release");

    a_insert_k285: assert property (
        device_reset_n && ins_now |-> sk_in_data == K28_5_CHAR && !pop ##1 char_inserted
            && st_r.rptr == $past(st_r.rptr))
        else $error("insertion not a framing character");

    a_drop_frame: assert property (
        device_reset_n && drop_now |=> char_dropped && st_r.fill <= $past(st_r.fill)
            && st_r.wptr == $past(st_r.wptr))
        else $error("framing character not discarded");

    a_bypass_pass: assert property (
        device_reset_n && !eb_active && rx_char_valid && rx_char_ready
        ##1 rx_out_ready |-> rx_out_valid)
        else $error("bypassed character not delivered");

endmodule : serdes_ctrl

/* File: verification/remote_xcvr_model.sv */
// Remote transceiver model: recovered characters and serial line bits.
// Assumes calls arrive just after a rising edge of sys_clk.
`timescale 1ns/1ps
module remote_xcvr_model (
    input wire logic sys_clk,
    input wire logic rx_char_ready,
    output logic rx_char_valid,
    output logic [8:0] rx_char,
    output logic primary_serial_input,
    output logic secondary_serial_input
);
    // ==========================================
    // Character sender and line drivers
    // ==========================================
    // Idle levels at time zero
    initial begin
        rx_char_valid = 1'b0;
        rx_char = 9'h0_00;
        primary_serial_input = 1'b0;
        secondary_serial_input = 1'b1;
    end

    // Valid stays up across a burst; each char holds until ready is sampled
    task automatic send_seq(input logic [8:0] q[$]);
        foreach (q[i]) begin
            rx_char_valid = 1'b1;
            rx_char = q[i];
            @(posedge sys_clk);
            while (rx_char_ready !== 1'b1) @(posedge sys_clk);
            #1;
        end
        rx_char_valid = 1'b0;
        rx_char = ~rx_char; // Released bus shows no stale value
    endtask : send_seq

    // Set both serial line levels
    task automatic set_lines(input logic p, input logic s);
        primary_serial_input = p;
        secondary_serial_input = s;
    endtask : set_lines
endmodule : remote_xcvr_model

/* File: verification/testbench.sv */
// Self-checking bench for the transceiver control block.
// Assumes the remote model drives the character and serial inputs.
`timescale 1ns/1ps
module testbench;
    import serdes_ctrl_pkg::*;
    logic sys_clk, rst_n, device_reset_n, decoder_enable, oe_le, st_le, rx_le;
    logic [1:0] rate_sel, tx_reference_rate_select_sel, txck_sel, rxck_sel, boe;
    logic in_sel, loop_en, tx_ser, rx_out_ready;
    logic p_in, s_in, c_valid, c_ready, o_valid, cdr, so_p, so_s, st_rxp, dev_rdy;
    logic ins, drp, ovf, cfg_err;
    logic [8:0] c_data, o_char;
    logic [1:0] so_en, st_en;
    rate_range_t rng;
    logic [8:0] got[$];
    logic [8:0] seq[$];
    int fail_count = 0, checks = 0, drops = 0, inserts = 0, ovfs = 0;

    serdes_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .device_reset_n(device_reset_n),
        .serial_rate_range_select(rate_sel), .tx_reference_rate_select(tx_reference_rate_select_sel),
        .tx_clock_source_select(txck_sel), .rx_clock_source_select(rxck_sel),
        .decoder_enable(decoder_enable), .boe(boe), .output_enable_latch_enable(oe_le),
        .selftest_latch_enable(st_le), .rx_power_latch_enable(rx_le),
        .serial_input_select(in_sel), .primary_serial_input(p_in),
        .secondary_serial_input(s_in), .loopback_enable(loop_en), .tx_serial_stream(tx_ser),
        .rx_char_valid(c_valid), .rx_char_ready(c_ready), .rx_char(c_data),
        .rx_out_valid(o_valid), .rx_out_ready(rx_out_ready), .rx_out_char(o_char),
        .pll_range(rng), .tx_capture_on_ref(), .rx_out_on_ref(), .rx_out_on_recovered(),
        .config_error(cfg_err), .cdr_serial_in(cdr), .serial_out_primary(so_p),
        .serial_out_secondary(so_s), .serial_out_en(so_en), .selftest_en(st_en),
        .rx_power_en(st_rxp), .char_inserted(ins), .char_dropped(drp), .eb_overflow(ovf),
        .device_ready(dev_rdy));

    remote_xcvr_model i_far (.sys_clk(sys_clk), .rx_char_ready(c_ready),
        .rx_char_valid(c_valid), .rx_char(c_data), .primary_serial_input(p_in),
        .secondary_serial_input(s_in));

    // ==========================================
    // Clock, monitor, helpers
    // ==========================================
    // 100 MHz reference clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Collect delivered characters and count event pulses
    always @(posedge sys_clk) begin
        if (o_valid === 1'b1 && rx_out_ready === 1'b1)
            got.push_back(o_char);
        if (drp === 1'b1)
            drops++;
        if (ins === 1'b1)
            inserts++;
        if (ovf === 1'b1)
            ovfs++;
    end

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Count edges from release until ready, bounded
    task automatic time_ready();
        int n;
        n = 0;
        while (dev_rdy !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        check(16'(n < 16), 16'h0001);
    endtask : time_ready

    task automatic wrap_up();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // Watchdog at 10,000 cycles, far beyond the expected hundred or so
    initial begin
        #100_000;
        fail_count++;
        wrap_up();
    end

    // ==========================================
    // Test sequence
    // ==========================================
    initial begin
        rst_n = 1'b0;
        device_reset_n = 1'b0;
        {rate_sel, tx_reference_rate_select_sel, txck_sel, rxck_sel} = 8'h5_0;
        decoder_enable = 1'b1;
        {boe, oe_le, st_le, rx_le} = 5'h0_0;
        {in_sel, loop_en, tx_ser, rx_out_ready} = 4'h0;
        repeat (6) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        device_reset_n = 1'b1;
        time_ready();
        $display("test reset done");

        // Stall output, overfill with framing chars, then two data chars
        seq = {K28_5_CHAR, K28_5_CHAR, K28_5_CHAR, K28_5_CHAR, K28_5_CHAR, K28_5_CHAR};
        seq.push_back(9'h0_41);
        seq.push_back(9'h0_42);
        i_far.send_seq(seq);
        step(3);
        rx_out_ready = 1'b1;
        step(20);
        check(16'(got[0]), 16'(K28_5_CHAR));
        seq = {};
        foreach (got[i])
            if (got[i] !== K28_5_CHAR)
                seq.push_back(got[i]);
        check(16'(seq.size()), 16'h0002);
        check(16'(seq[0]), 16'h0041);
        check(16'(seq[1]), 16'h0042);
        check(16'(drops > 0), 16'h0001);
        check(16'(ovfs), 16'h0000);
        // One framing char then idle: exactly one K28.5 is added after it
        got = {};
        inserts = 0;
        seq = {K28_5_CHAR};
        i_far.send_seq(seq);
        step(30);
        check(16'(inserts), 16'h0001);
        check(16'(got.size()), 16'h0002);
        foreach (got[i])
            check(16'(got[i]), 16'(K28_5_CHAR));
        $display("test elasticity done");

        // Bypass mode passes one char straight through
        rxck_sel = TERN_MID_CODE;
        step(3);
        got = {};
        seq = {9'h1_7c};
        i_far.send_seq(seq);
        step(3);
        check(16'(got.size()), 16'h0001);
        check(16'(got[0]), 16'h017c);
        $display("test bypass done");

        // Every ternary code, floating read as middle
        for (int i = 0; i < 4; i++) begin
            rate_sel = 2'(i);
            #2;
            check(16'(rng), (i == 0) ? 16'(RANGE_LOW) : (i == 2) ? 16'(RANGE_HIGH)
                : 16'(RANGE_MID));
            check(16'(cfg_err), 16'h0000);
            step(1);
        end
        rate_sel = TERN_MID_CODE;
        for (int i = 0; i < 4; i++) begin
            txck_sel = 2'(i);
            rxck_sel = (i == 2) ? TERN_MID_CODE : 2'(i);
            #2;
            check(16'(i_dut.tx_capture_on_ref), 16'(i == 0));
            check(16'(i_dut.rx_out_on_ref), 16'(i == 0));
            check(16'(i_dut.rx_out_on_recovered), 16'(i != 0));
            step(1);
        end
        // Receive select high is an invalid mode and is flagged
        rxck_sel = TERN_HIGH_CODE;
        #2;
        check(16'(cfg_err), 16'h0001);
        step(1);
        rxck_sel = TERN_MID_CODE;
        $display("test ternary done");

        // Load the three latches, then close them
        {boe, oe_le, rx_le} = 4'hf;
        step(1);
        {oe_le, rx_le, boe, st_le} = 5'h0_1;
        step(1);
        {st_le, boe} = 3'h3;
        step(1);
        check(16'(so_en), 16'h0003);
        check(16'(st_en), 16'h0003);
        check(16'(st_rxp), 16'h0001);

        // Loopback forces drivers high and ignores both inputs
        loop_en = 1'b1;
        i_far.set_lines(1'b1, 1'b1);
        step(2);
        check(16'({so_p, so_s, cdr}), 16'h0006);
        tx_ser = 1'b1;
        i_far.set_lines(1'b0, 1'b0);
        step(1);
        check(16'(cdr), 16'h0001);
        // Input select picks primary high, secondary low
        {loop_en, tx_ser, in_sel} = 3'h1;
        i_far.set_lines(1'b0, 1'b1);
        step(2);
        check(16'({so_p, cdr}), 16'h0000);
        in_sel = 1'b0;
        step(1);
        check(16'(cdr), 16'h0001);
        $display("test serial done");

        // Device reset clears the output-enable and power latches and the drivers, and sets the selftest latch
        device_reset_n = 1'b0;
        step(2);
        check(16'({so_en, st_en, st_rxp, so_p, so_s, dev_rdy}), 16'h0000);
        device_reset_n = 1'b1;
        time_ready();
        check(16'({so_en, st_en, st_rxp}), 16'h0000);
        $display("test device reset done");
        wrap_up();
    end
endmodule : testbench
